/* src/edo_ctrl_pkg.sv */
// Package for the extended-output DRAM strobe controller: pin bundle, request, states, timing
package edo_ctrl_pkg;

    // Clock and widths
    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_W        = 10;
    localparam int DATA_W        = 16;
    localparam int WADDR_W       = 20;
    localparam int ROW_LSB       = 10;
    localparam int CNT_W         = 16;

    // Strobe timings in ns; plain defaults, adjust for the speed grade in use
    localparam int T_RAS_NS  = 50;
    localparam int T_RP_NS   = 30;
    localparam int T_RCD_NS  = 20;
    localparam int T_CAC_NS  = 15;
    localparam int T_CP_NS   = 10;
    localparam int T_CSR_NS  = 10;
    localparam int T_RASS_NS = 100000;
    localparam int T_INIT_NS = 200000;

    // Refresh budget
    localparam int T_REF_PERIOD_NS = 16000000;
    localparam int REF_ROWS        = 1024;
    localparam int INIT_CYCLES     = 8;

    // Least time rounds up, never below one cycle
    function automatic logic [CNT_W-1:0] cyc_min(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        if (c < 1) begin
            c = 1;
        end
        return CNT_W'(c);
    endfunction

    // Longest time rounds down, never below one cycle
    function automatic logic [CNT_W-1:0] cyc_max(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        if (c < 1) begin
            c = 1;
        end
        return CNT_W'(c);
    endfunction

    localparam logic [CNT_W-1:0] CYC_RAS  = cyc_min(T_RAS_NS);
    localparam logic [CNT_W-1:0] CYC_RP   = cyc_min(T_RP_NS);
    localparam logic [CNT_W-1:0] CYC_RCD  = cyc_min(T_RCD_NS);
    localparam logic [CNT_W-1:0] CYC_CAC  = cyc_min(T_CAC_NS);
    localparam logic [CNT_W-1:0] CYC_CP   = cyc_min(T_CP_NS);
    localparam logic [CNT_W-1:0] CYC_CSR  = cyc_min(T_CSR_NS);
    localparam logic [CNT_W-1:0] CYC_RASS = cyc_min(T_RASS_NS);
    localparam logic [CNT_W-1:0] CYC_INIT = cyc_min(T_INIT_NS);
    localparam logic [CNT_W-1:0] CYC_REF  = cyc_max(T_REF_PERIOD_NS / REF_ROWS);

    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
    localparam logic [3:0]       INIT_LEFT_RST = 4'(INIT_CYCLES);

    // Pins toward the DRAM
    typedef struct packed {
        logic              ras_n;
        logic              low_byte_col_strobe_n;
        logic              high_byte_col_strobe_n;
        logic              we_n;
        logic              oe_n;
        logic [ADDR_W-1:0] mux_address_bus;
        logic [DATA_W-1:0] data_lanes_out;
        logic [DATA_W-1:0] data_lanes_oe;
    } dram_pins_t;

    localparam dram_pins_t PINS_RST = '{
        ras_n: 1'b1, low_byte_col_strobe_n: 1'b1, high_byte_col_strobe_n: 1'b1,
        we_n: 1'b1, oe_n: 1'b1, mux_address_bus: 10'h000,
        data_lanes_out: 16'h0000, data_lanes_oe: 16'h0000};

    // User request
    typedef struct packed {
        logic               write;
        logic [1:0]         byte_en;
        logic [WADDR_W-1:0] addr;
        logic [DATA_W-1:0]  wdata;
    } req_t;

    typedef enum logic [9:0] {
        S_INIT_WAIT = 10'h001,
        S_IDLE      = 10'h002,
        S_ROW       = 10'h004,
        S_CSET      = 10'h008,
        S_COL       = 10'h010,
        S_CPRE      = 10'h020,
        S_PRE       = 10'h040,
        S_REF_COL   = 10'h080,
        S_REF_ROW   = 10'h100,
        S_SELF      = 10'h200
    } state_t;

    function automatic logic [ADDR_W-1:0] row_of(input logic [WADDR_W-1:0] a);
        return a[WADDR_W-1:ROW_LSB];
    endfunction

    function automatic logic [ADDR_W-1:0] col_of(input logic [WADDR_W-1:0] a);
        return a[ROW_LSB-1:0];
    endfunction

    // Lane drive enables from byte enables: bit 0 lanes 7:0, bit 1 lanes 15:8
    function automatic logic [DATA_W-1:0] lane_oe(input logic [1:0] be);
        return {{8{be[1]}}, {8{be[0]}}};
    endfunction

endpackage

/* src/edo_ctrl.sv */
// Extended-output DRAM strobe controller: accesses, page mode, refresh, self refresh, power-up
`timescale 1ns/1ps
`default_nettype none

module edo_ctrl
    import edo_ctrl_pkg::*;
#(
    parameter logic [CNT_W-1:0] INIT_WAIT_CYC  = CYC_INIT,
    parameter logic [CNT_W-1:0] SELF_ENTRY_CYC = CYC_RASS
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              arst_n,
    // User request side
    input  wire logic              req_valid,
    input  wire req_t              req,
    input  wire logic              sr_req,
    output var  logic              req_taken,
    output var  logic              rsp_valid,
    output var  logic [DATA_W-1:0] rsp_rdata,
    output var  logic              init_done,
    output var  logic              sr_active,
    // DRAM pins
    output var  dram_pins_t        pins,
    input  wire logic [DATA_W-1:0] data_lanes_in
);

    typedef struct packed {
        state_t             state;
        logic [CNT_W-1:0]   cnt;
        logic [CNT_W-1:0]   ras_cnt;
        logic [CNT_W-1:0]   ref_cnt;
        logic               ref_pend;
        logic [3:0]         init_left;
        logic               init_done;
        logic               sr_active;
        logic               write;
        logic [1:0]         be;
        logic [ADDR_W-1:0]  row;
        logic [ADDR_W-1:0]  col;
        logic [DATA_W-1:0]  wdata;
        dram_pins_t         pins;
        logic               req_taken;
        logic               rsp_valid;
        logic [DATA_W-1:0]  rdata;
    } ctrl_t;

    ctrl_t r;
    ctrl_t n;
    logic  ref_tick;
    logic  ref_clear;
    logic  ref_force;
    logic  page_hit;

    // Next-state logic for the whole controller
    always_comb begin
        n = r;
        n.req_taken = 1'b0;
        n.rsp_valid = 1'b0;
        ref_clear = 1'b0;
        ref_force = 1'b0;
        if (r.cnt != CNT_ZERO) begin
            n.cnt = r.cnt - CNT_ONE;
        end
        // Row-active floor runs from every row strobe fall
        if (r.ras_cnt != CNT_ZERO) begin
            n.ras_cnt = r.ras_cnt - CNT_ONE;
        end
        // One refresh due every 1,563 cycles: 16 ms / 1,024 rows rounded down, plus one
        ref_tick = (r.ref_cnt == CNT_ZERO);
        n.ref_cnt = ref_tick ? CYC_REF : r.ref_cnt - CNT_ONE;
        page_hit = req_valid && (row_of(req.addr) == r.row) && !r.ref_pend && !sr_req;

        unique case (r.state)
            S_INIT_WAIT: begin
                // Strobes parked high through the power-up pause
                if (r.cnt == CNT_ZERO) begin
                    n.pins.low_byte_col_strobe_n = 1'b0;
                    n.pins.high_byte_col_strobe_n = 1'b0;
                    n.cnt = CYC_CSR;
                    n.state = S_REF_COL;
                end
            end
            S_IDLE: begin
                // Refresh and init cycles beat new accesses; refresh only between rows
                if (r.ref_pend || r.init_left != 4'h0 || (sr_req && r.init_done)) begin
                    n.pins.low_byte_col_strobe_n = 1'b0;
                    n.pins.high_byte_col_strobe_n = 1'b0;
                    n.pins.data_lanes_oe = '0;
                    n.cnt = CYC_CSR;
                    n.state = S_REF_COL;
                end else if (req_valid) begin
                    n.req_taken = 1'b1;
                    n.write = req.write;
                    n.be = req.byte_en;
                    n.row = row_of(req.addr);
                    n.col = col_of(req.addr);
                    n.wdata = req.wdata;
                    n.pins.mux_address_bus = row_of(req.addr);
                    n.pins.ras_n = 1'b0;
                    n.ras_cnt = CYC_RAS;
                    n.cnt = CYC_RCD;
                    n.state = S_ROW;
                end
            end
            S_ROW: begin
                // Column on the bus and write data driven one cycle ahead of the strobe
                if (r.cnt == CNT_ZERO) begin
                    n.pins.mux_address_bus = r.col;
                    n.pins.we_n = ~r.write;
                    n.pins.data_lanes_out = r.wdata;
                    n.pins.data_lanes_oe = r.write ? lane_oe(r.be) : '0;
                    n.state = S_CSET;
                end
            end
            S_CSET: begin
                // Only the enabled byte strobes fall; output gate with them for reads
                n.pins.low_byte_col_strobe_n = ~r.be[0];
                n.pins.high_byte_col_strobe_n = ~r.be[1];
                n.pins.oe_n = r.write;
                n.cnt = CYC_CAC;
                n.state = S_COL;
            end
            S_COL: begin
                // Column address held and strobes low until access time has run
                if (r.cnt == CNT_ZERO) begin
                    if (!r.write) begin
                        n.rsp_valid = 1'b1;
                        n.rdata = data_lanes_in;
                    end
                    n.pins.low_byte_col_strobe_n = 1'b1;
                    n.pins.high_byte_col_strobe_n = 1'b1;
                    n.pins.oe_n = 1'b1;
                    n.pins.we_n = 1'b1;
                    n.pins.data_lanes_oe = '0;
                    n.cnt = CYC_CP;
                    n.state = S_CPRE;
                end
            end
            S_CPRE: begin
                // Column precharge; same row keeps the page open
                if (r.cnt == CNT_ZERO) begin
                    if (page_hit) begin
                        n.req_taken = 1'b1;
                        n.write = req.write;
                        n.be = req.byte_en;
                        n.col = col_of(req.addr);
                        n.wdata = req.wdata;
                        n.pins.mux_address_bus = col_of(req.addr);
                        n.pins.we_n = ~req.write;
                        n.pins.data_lanes_out = req.wdata;
                        n.pins.data_lanes_oe = req.write ? lane_oe(req.byte_en) : '0;
                        n.state = S_CSET;
                    end else if (r.ras_cnt == CNT_ZERO) begin
                        n.pins.ras_n = 1'b1;
                        n.cnt = CYC_RP;
                        n.state = S_PRE;
                    end
                end
            end
            S_PRE: begin
                // Row precharge before any new row strobe fall
                if (r.cnt == CNT_ZERO) begin
                    n.state = S_IDLE;
                end
            end
            S_REF_COL: begin
                // Column strobes settled low, now the row strobe falls
                if (r.cnt == CNT_ZERO) begin
                    n.pins.ras_n = 1'b0;
                    n.ras_cnt = CYC_RAS;
                    n.cnt = CYC_RAS;
                    ref_clear = 1'b1;
                    n.state = S_REF_ROW;
                end
            end
            S_REF_ROW: begin
                if (r.cnt == CNT_ZERO) begin
                    if (sr_req && r.init_done) begin
                        // Keep the row strobe low: the device slips into self refresh
                        n.cnt = SELF_ENTRY_CYC;
                        n.state = S_SELF;
                    end else begin
                        n.pins.ras_n = 1'b1;
                        n.pins.low_byte_col_strobe_n = 1'b1;
                        n.pins.high_byte_col_strobe_n = 1'b1;
                        n.cnt = CYC_RP;
                        n.state = S_PRE;
                        if (r.init_left != 4'h0) begin
                            n.init_left = r.init_left - 4'h1;
                            n.init_done = (r.init_left == 4'h1);
                        end
                    end
                end
            end
            S_SELF: begin
                // Leaving early would cut short the minimum entry hold
                if (r.cnt == CNT_ZERO) begin
                    n.sr_active = 1'b1;
                    if (!sr_req) begin
                        n.pins.ras_n = 1'b1;
                        n.pins.low_byte_col_strobe_n = 1'b1;
                        n.pins.high_byte_col_strobe_n = 1'b1;
                        n.sr_active = 1'b0;
                        n.cnt = CYC_RP;
                        ref_force = 1'b1;
                        n.state = S_PRE;
                    end
                end
            end
            default: begin
                n.state = S_IDLE;
            end
        endcase

        // A refresh falling due in the clearing cycle is kept
        n.ref_pend = ref_tick | ref_force | (r.ref_pend & ~ref_clear);
    end

    // State register; strobes high and lanes released in reset
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            r.state     <= S_INIT_WAIT;
            r.cnt       <= INIT_WAIT_CYC;
            r.ras_cnt   <= CNT_ZERO;
            r.ref_cnt   <= CYC_REF;
            r.ref_pend  <= 1'b0;
            r.init_left <= INIT_LEFT_RST;
            r.init_done <= 1'b0;
            r.sr_active <= 1'b0;
            r.write     <= 1'b0;
            r.be        <= 2'h0;
            r.row       <= 10'h000;
            r.col       <= 10'h000;
            r.wdata     <= 16'h0000;
            r.pins      <= PINS_RST;
            r.req_taken <= 1'b0;
            r.rsp_valid <= 1'b0;
            r.rdata     <= 16'h0000;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state register
    assign req_taken = r.req_taken;
    assign rsp_valid = r.rsp_valid;
    assign rsp_rdata = r.rdata;
    assign init_done = r.init_done;
    assign sr_active = r.sr_active;
    assign pins      = r.pins;

endmodule

`default_nettype wire

/* tb/edo_ctrl_chk.sv */
// Port-level assertion checker for the extended-output strobe controller
`timescale 1ns/1ps
`default_nettype none
module edo_ctrl_chk
    import edo_ctrl_pkg::*;
#(
    parameter logic [CNT_W-1:0] INIT_WAIT_CYC  = CYC_INIT,
    parameter logic [CNT_W-1:0] SELF_ENTRY_CYC = CYC_RASS
) (
    // Clock and reset
    input wire logic              mclk,
    input wire logic              arst_n,
    // User side
    input wire logic              req_valid,
    input wire req_t              req,
    input wire logic              sr_req,
    input wire logic              req_taken,
    input wire logic              rsp_valid,
    input wire logic [DATA_W-1:0] rsp_rdata,
    input wire logic              init_done,
    input wire logic              sr_active,
    // DRAM side
    input wire dram_pins_t        pins,
    input wire logic [DATA_W-1:0] data_lanes_in
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // Short names for the strobes, write enable and lane drive enables
    wire logic              ras_n = pins.ras_n;
    wire logic              lo_n  = pins.low_byte_col_strobe_n;
    wire logic              hi_n  = pins.high_byte_col_strobe_n;
    wire logic              we_n  = pins.we_n;
    wire logic [DATA_W-1:0] loe   = pins.data_lanes_oe;
    // Column must sit still over the strobe fall and one cycle after
    sequence col_held;
        $stable(pins.mux_address_bus) ##1 $stable(pins.mux_address_bus);
    endsequence
    a_standby_quiet: assert property (
        ras_n && lo_n && hi_n |-> loe == '0) else $error("lanes driven in standby");
    a_write_setup: assert property (
        $fell(lo_n) && !ras_n && !we_n |-> $past(loe[7:0]) == 8'hFF) else $error("data late");
    a_idle_lane: assert property (
        !ras_n && !we_n && !lo_n && hi_n |-> loe[15:8] == 8'h00) else $error("idle lane driven");
    a_row_active: assert property (
        $fell(ras_n) |-> !ras_n [*5]) else $error("row cycle too short");
    a_row_precharge: assert property (
        $rose(ras_n) |-> ras_n [*3]) else $error("precharge too short");
    a_refresh_order: assert property (
        $fell(ras_n) && !lo_n |-> !hi_n && $past(lo_n, 2) == 1'b0) else $error("refresh order");
    a_col_hold: assert property (
        ($fell(lo_n) || $fell(hi_n)) && !ras_n |-> col_held) else $error("column moved");
    a_read_lanes: assert property (
        rsp_valid |-> ((rsp_rdata ^ $past(data_lanes_in))
        & {{8{!$past(hi_n)}}, {8{!$past(lo_n)}}}) == '0) else $error("read lanes wrong");
    a_self_quiet: assert property (
        sr_active |-> !ras_n && pins.oe_n && loe == '0) else $error("self refresh not quiet");
endmodule
bind edo_ctrl edo_ctrl_chk #(.INIT_WAIT_CYC(INIT_WAIT_CYC), .SELF_ENTRY_CYC(SELF_ENTRY_CYC))
    chk (.mclk(mclk), .arst_n(arst_n), .req_valid(req_valid), .req(req), .sr_req(sr_req),
    .req_taken(req_taken), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .init_done(init_done), .sr_active(sr_active), .pins(pins), .data_lanes_in(data_lanes_in));
`default_nettype wire

/* tb/edo_dram_model.sv */
// Behavioural extended-output DRAM answering the controller's strobes
`timescale 1ns/1ps
`default_nettype none
module edo_dram_model
    import edo_ctrl_pkg::*;
(
    // Clock and pins
    input  wire logic              mclk,
    input  wire dram_pins_t        pins,
    // Wire levels and refresh tally
    output var  logic [DATA_W-1:0] data_lanes_in,
    output var  int                refresh_count
);
    logic [DATA_W-1:0] mem [int];
    logic [1:0]        s_n, p_n;
    logic              pras_n = 1'b1;
    logic [ADDR_W-1:0] row_r  = 10'h000;
    logic [DATA_W-1:0] rd_r   = 16'h0000;
    logic [DATA_W-1:0] last_r = 16'h0000;
    logic [DATA_W-1:0] drv;
    int                k;
    int                ref_n  = 0;
    // Tally kept in one process only, port follows it
    assign refresh_count = ref_n;
    assign s_n = {pins.high_byte_col_strobe_n, pins.low_byte_col_strobe_n};
    // Each byte strobe opens only its own lane, reads only
    assign drv = {{8{!s_n[1]}}, {8{!s_n[0]}}} & {16{!pins.ras_n && !pins.oe_n && pins.we_n}};
    // Released lanes show the inverse of their last level, never a stale copy
    assign data_lanes_in = (pins.data_lanes_oe & pins.data_lanes_out)
        | (~pins.data_lanes_oe & ((drv & rd_r) | (~drv & ~last_r)));
    // Edges seen one clock late, so fresh data lags the strobe like access time
    always @(posedge mclk) begin
        pras_n <= pins.ras_n;
        p_n    <= s_n;
        last_r <= data_lanes_in;
        if (pras_n && !pins.ras_n) begin
            if (s_n != 2'b11) begin
                ref_n <= ref_n + 1;
            end else begin
                row_r <= pins.mux_address_bus;
            end
        end
        for (int b = 0; b < 2; b++) begin
            if (!pins.ras_n && p_n[b] && !s_n[b]) begin
                k = int'({row_r, pins.mux_address_bus});
                if (!mem.exists(k)) mem[k] = 16'h5A5A;
                if (!pins.we_n) mem[k][b*8 +: 8] = pins.data_lanes_out[b*8 +: 8];
                rd_r[b*8 +: 8] <= mem[k][b*8 +: 8];
            end
        end
    end
endmodule
`default_nettype wire

/* tb/test_edo_dram_strobe_interface.sv */
// Self-checking bench: controller, behavioural DRAM and a reference memory
`timescale 1ns/1ps
`default_nettype none
module test_edo_dram_strobe_interface
    import edo_ctrl_pkg::*;
;
    logic              mclk, arst_n, req_valid, sr_req, req_taken, rsp_valid;
    logic              init_done, sr_active;
    logic [1:0]        be;
    logic [19:0]       a;
    logic [19:0]       wq [$];
    req_t              req;
    dram_pins_t        pins;
    logic [DATA_W-1:0] rsp_rdata, data_lanes_in;
    logic [DATA_W-1:0] ref_mem [int];
    int                bad_count, comparisons, refresh_count, c0, lim;
    // Short power-up and self refresh holds keep the run brief
    edo_ctrl #(.INIT_WAIT_CYC(16'h0014), .SELF_ENTRY_CYC(16'h000A)) dut (
        .mclk(mclk), .arst_n(arst_n), .req_valid(req_valid), .req(req), .sr_req(sr_req),
        .req_taken(req_taken), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .init_done(init_done), .sr_active(sr_active), .pins(pins),
        .data_lanes_in(data_lanes_in));
    edo_dram_model dram (.mclk(mclk), .pins(pins), .data_lanes_in(data_lanes_in),
        .refresh_count(refresh_count));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic conclude();
        if (bad_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Bounded wait at falling edges; running out ends the run
    task automatic wait_lvl(ref logic sig, input logic lvl);
        lim = 0;
        while (sig !== lvl) begin
            @(negedge mclk);
            lim++;
            if (lim > 600) begin
                bad_count++;
                conclude();
            end
        end
    endtask
    // One request held until taken; reads compared on the strobed lanes only
    task automatic access(input logic wr, input logic [1:0] b, input logic [19:0] ad,
                          input logic [15:0] d);
        logic [15:0] m;
        m = {{8{b[1]}}, {8{b[0]}}};
        @(negedge mclk);
        req_valid = 1'b1;
        req = '{write: wr, byte_en: b, addr: ad, wdata: d};
        wait_lvl(req_taken, 1'b1);
        req_valid = 1'b0;
        if (wr) begin
            if (!ref_mem.exists(ad)) wq.push_back(ad);
            if (!ref_mem.exists(ad)) ref_mem[ad] = d;
            ref_mem[ad] = (ref_mem[ad] & ~m) | (d & m);
        end else begin
            wait_lvl(rsp_valid, 1'b1);
            chk(rsp_rdata & m, ref_mem[ad] & m);
        end
    endtask
    initial begin
        arst_n = 1'b0;
        req_valid = 1'b0;
        sr_req = 1'b0;
        req = '0;
        bad_count = 0;
        comparisons = 0;
        void'($urandom(19959));
        repeat (20) @(negedge mclk);
        arst_n = 1'b1;
        chk(16'(init_done), 16'h0000);
        wait_lvl(init_done, 1'b1);
        chk(16'(refresh_count >= INIT_CYCLES), 16'h0001);
        // Few rows and columns, so page hits, misses and byte merges all occur
        for (int i = 0; i < 80; i++) begin
            a = {10'($urandom_range(0, 1)) ^ ((i % 4 == 3) ? 10'h3FF : 10'h000),
                 10'($urandom_range(0, 15))};
            be = ref_mem.exists(a) ? 2'($urandom_range(1, 3)) : 2'b11;
            if (wq.size() < 4 || $urandom_range(0, 1)) begin
                access(1'b1, be, a, 16'($urandom));
            end else begin
                access(1'b0, be, wq[$urandom_range(0, wq.size() - 1)], 16'h0000);
            end
        end
        // Same-row requests back to back: page writes then page reads
        for (int j = 0; j < 8; j++) begin
            access(j < 4, 2'b11, {10'h155, 10'(j % 4)}, 16'(j * 16'h1357));
        end
        // Idle spell: distributed refresh keeps its own pace
        c0 = refresh_count;
        repeat (3200) @(negedge mclk);
        lim = 3200 / int'(CYC_REF);
        chk(16'(refresh_count - c0 >= lim && refresh_count - c0 <= lim + 1), 16'h0001);
        // Self refresh with a read left waiting; it may only go after release
        sr_req = 1'b1;
        wait_lvl(sr_active, 1'b1);
        fork
            access(1'b0, 2'b11, wq[0], 16'h0000);
            begin
                repeat (40) begin
                    @(negedge mclk);
                    chk(16'({sr_active, req_taken}), 16'h0002);
                end
                sr_req = 1'b0;
            end
        join
        for (int j = 1; j < 6; j++) access(1'b0, 2'b11, wq[j], 16'h0000);
        // Reset in mid-run: pins drop to standby at once, stored data survives
        @(negedge mclk);
        arst_n = 1'b0;
        #1;
        chk(16'({pins.ras_n, init_done, |pins.data_lanes_oe}), 16'h0004);
        repeat (20) @(negedge mclk);
        arst_n = 1'b1;
        wait_lvl(init_done, 1'b1);
        access(1'b0, 2'b11, wq[1], 16'h0000);
        conclude();
    end
endmodule
`default_nettype wire
